// file: seq_pkg.sv
package seq_pkg;

	localparam int NUM_CH = 6;
	localparam int WORD_W = 10;
	localparam int LEVEL_W = 11;
	localparam logic [2:0] FIRST_STEP = 3'h0;
	localparam logic [2:0] LAST_STEP = 3'h5;
	localparam logic [2:0] LAST_CH = 3'h5;
	localparam logic [WORD_W-1:0] CODE_MAX = 10'h3ff;
	localparam logic [WORD_W-1:0] CODE_RST = 10'h000;

	localparam logic [7:0] ADDR_CONTROL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_OUT_BASE = 8'h08;
	localparam logic [7:0] ADDR_STRIDE = 8'h04;

	localparam int CTRL_ENABLE_BIT = 0;
	localparam int CTRL_SOFT_LOW_POWER_HOLD_BIT = 1;
	localparam logic [1:0] CTRL_RST = 2'h1;

	localparam int ST_PEND_BIT = 0;
	localparam int ST_LOAD_BIT = 1;
	localparam int ST_STEP_LSB = 2;
	localparam int ST_POL_BIT = 5;
	localparam int ST_LOW_POWER_HOLD_BIT = 6;
	localparam int ST_START_BIT = 7;

	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic HRESP_OKAY = 1'b0;
	localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

	typedef enum logic [1:0] {
		SEQ_IDLE = 2'b01,
		SEQ_LOAD = 2'b10
	} seq_state_t;

	typedef struct packed {
		logic [WORD_W-1:0] word;
		logic start;
		logic edge_sel;
		logic dir;
		logic output_transfer;
		logic pol;
		logic low_power_hold;
		logic pclk;
	} pin_in_t;

	typedef struct packed {
		logic valid;
		logic write;
		logic [7:0] addr;
	} ahb_phase_t;

endpackage

// file: level_mapper.sv
`timescale 1ns/1ps
// Maps a code to a signed offset from the midpoint.
module level_mapper
	import seq_pkg::*;
(
	input wire logic [WORD_W-1:0] code,
	input wire logic polarity_select,
	output logic signed [LEVEL_W-1:0] level
);

	logic [WORD_W-1:0] deviation;

	always_comb begin
		deviation = CODE_MAX - code;
		if (polarity_select) begin
			level = $signed({1'b0, deviation});
		end else begin
			level = $signed(LEVEL_W'(0) - {1'b0, deviation});
		end
	end

endmodule

// file: column_load_sequencer.sv
// Our own choices: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
// Notes on behaviour
// - A valid start begins a six-edge load of six words into the holding stages.
// - Loading starts on an active edge when start was high the edge before.
// - Edge select high loads on rising pin clock edges, low on falling ones.
// - Direction high fills channel 0 up to 5, low fills 5 down to 0.
// - Transfer high at a rising edge moves all held words out at next fall.
// - Every channel loads from one shared 10-bit bus and feeds its own converter.
// - Polarity high: level is upper limit minus code; low: lower limit plus code.
// - Code 0 gives full-scale deviation, code 1023 gives the midpoint.
// - Standby clears all stored words and state; operation resumes when it drops.
// - Bus bit 9 is the most significant bit of each word.
module column_load_sequencer
	import seq_pkg::*;
(
	input wire logic CLOCK,
	input wire logic RST_N,
	input wire logic PANEL_CLK,
	input wire logic [WORD_W-1:0] INPUT_WORD_BUS,
	input wire logic SEQUENCE_START,
	input wire logic EDGE_SELECT,
	input wire logic LOAD_DIRECTION,
	input wire logic OUTPUT_TRANSFER,
	input wire logic POLARITY_SELECT,
	input wire logic LOW_POWER_HOLD,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	output logic [NUM_CH-1:0][WORD_W-1:0] COLUMN_CODE,
	output logic [NUM_CH-1:0][LEVEL_W-1:0] COLUMN_LEVEL
);

	pin_in_t pins_in;
	pin_in_t pin_meta_r;
	pin_in_t pin_sync_r;
	logic pclk_d_r;
	logic pclk_rise;
	logic pclk_fall;
	logic active_edge;
	logic low_power_hold_eff;
	logic start_seen_r;
	seq_state_t state_r;
	seq_state_t state_nxt;
	logic [2:0] step_r;
	logic [2:0] step_nxt;
	logic begin_seq;
	logic capture;
	logic [2:0] cap_step;
	logic [2:0] cap_chan;
	logic xfr_pend_r;
	logic [NUM_CH-1:0][WORD_W-1:0] hold_r;
	logic [NUM_CH-1:0][WORD_W-1:0] out_code_r;
	logic [NUM_CH-1:0][LEVEL_W-1:0] level_r;
	logic [NUM_CH-1:0][LEVEL_W-1:0] level_map;
	logic [1:0] ctrl_r;
	ahb_phase_t dphase_r;
	logic [31:0] rdata_nxt;

	assign pins_in = '{word: INPUT_WORD_BUS, start: SEQUENCE_START, edge_sel: EDGE_SELECT,
		dir: LOAD_DIRECTION, output_transfer: OUTPUT_TRANSFER, pol: POLARITY_SELECT,
		low_power_hold: LOW_POWER_HOLD, pclk: PANEL_CLK};

	// Two-stage synchroniser for every pin, panel clock included.
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			pin_meta_r <= '0;
			pin_sync_r <= '0;
		end else begin
			pin_meta_r <= pins_in;
			pin_sync_r <= pin_meta_r;
		end
	end

	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			pclk_d_r <= 1'b0;
		end else begin
			pclk_d_r <= pin_sync_r.pclk;
		end
	end

	assign pclk_rise = pin_sync_r.pclk & ~pclk_d_r;
	assign pclk_fall = ~pin_sync_r.pclk & pclk_d_r;
	assign active_edge = pin_sync_r.edge_sel ? pclk_rise : pclk_fall;
	assign low_power_hold_eff = pin_sync_r.low_power_hold | ctrl_r[CTRL_SOFT_LOW_POWER_HOLD_BIT];

	// Start is remembered from one active edge to the next.
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			start_seen_r <= 1'b0;
		end else if (low_power_hold_eff) begin
			start_seen_r <= 1'b0;
		end else if (active_edge) begin
			start_seen_r <= pin_sync_r.start;
		end
	end

	assign begin_seq = active_edge && start_seen_r && ctrl_r[CTRL_ENABLE_BIT];
	assign capture = active_edge && (begin_seq || state_r == SEQ_LOAD);
	assign cap_step = begin_seq ? FIRST_STEP : step_r;
	assign cap_chan = pin_sync_r.dir ? cap_step : LAST_CH - cap_step;

	always_comb begin
		state_nxt = state_r;
		step_nxt = step_r;
		case (state_r)
			SEQ_IDLE: begin
				if (begin_seq) begin
					state_nxt = SEQ_LOAD;
					step_nxt = FIRST_STEP + 3'h1;
				end
			end
			SEQ_LOAD: begin
				if (begin_seq) begin
					step_nxt = FIRST_STEP + 3'h1;
				end else if (active_edge && step_r == LAST_STEP) begin
					state_nxt = SEQ_IDLE;
					step_nxt = FIRST_STEP;
				end else if (active_edge) begin
					step_nxt = step_r + 3'h1;
				end
			end
			default: begin
				state_nxt = SEQ_IDLE;
				step_nxt = FIRST_STEP;
			end
		endcase
	end

	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			state_r <= SEQ_IDLE;
			step_r <= FIRST_STEP;
		end else if (low_power_hold_eff) begin
			state_r <= SEQ_IDLE;
			step_r <= FIRST_STEP;
		end else begin
			state_r <= state_nxt;
			step_r <= step_nxt;
		end
	end

	// Transfer request is caught on a rising edge and served on the next falling one.
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			xfr_pend_r <= 1'b0;
		end else if (low_power_hold_eff) begin
			xfr_pend_r <= 1'b0;
		end else if (pclk_rise && pin_sync_r.output_transfer) begin
			xfr_pend_r <= 1'b1;
		end else if (pclk_fall) begin
			xfr_pend_r <= 1'b0;
		end
	end

	genvar ch;
	generate
		for (ch = 0; ch < NUM_CH; ch++) begin : g_chan
			always_ff @(posedge CLOCK or negedge RST_N) begin
				if (!RST_N) begin
					hold_r[ch] <= CODE_RST;
				end else if (low_power_hold_eff) begin
					hold_r[ch] <= CODE_RST;
				end else if (capture && cap_chan == 3'(ch)) begin
					hold_r[ch] <= pin_sync_r.word;
				end
			end

			always_ff @(posedge CLOCK or negedge RST_N) begin
				if (!RST_N) begin
					out_code_r[ch] <= CODE_RST;
				end else if (low_power_hold_eff) begin
					out_code_r[ch] <= CODE_RST;
				end else if (pclk_fall && xfr_pend_r) begin
					out_code_r[ch] <= hold_r[ch];
				end
			end

			level_mapper u_map (
				.code(out_code_r[ch]),
				.polarity_select(pin_sync_r.pol),
				.level(level_map[ch])
			);

			always_ff @(posedge CLOCK or negedge RST_N) begin
				if (!RST_N) begin
					level_r[ch] <= LEVEL_W'(0);
				end else begin
					level_r[ch] <= level_map[ch];
				end
			end
		end
	endgenerate

	assign COLUMN_CODE = out_code_r;
	assign COLUMN_LEVEL = level_r;

	// AHB-Lite slave with zero wait states.
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			dphase_r <= '0;
		end else if (HREADY) begin
			dphase_r.valid <= HSEL && HTRANS == HTRANS_NONSEQ;
			dphase_r.write <= HWRITE;
			dphase_r.addr <= HADDR[7:0];
		end
	end

	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			ctrl_r <= CTRL_RST;
		end else if (dphase_r.valid && dphase_r.write && dphase_r.addr == ADDR_CONTROL) begin
			ctrl_r <= HWDATA[1:0];
		end
	end

	always_comb begin
		rdata_nxt = RDATA_ZERO;
		if (HADDR[7:0] == ADDR_CONTROL) begin
			rdata_nxt[1:0] = ctrl_r;
		end else if (HADDR[7:0] == ADDR_STATUS) begin
			rdata_nxt[ST_PEND_BIT] = xfr_pend_r;
			rdata_nxt[ST_LOAD_BIT] = state_r == SEQ_LOAD;
			rdata_nxt[ST_STEP_LSB +: 3] = step_r;
			rdata_nxt[ST_POL_BIT] = pin_sync_r.pol;
			rdata_nxt[ST_LOW_POWER_HOLD_BIT] = low_power_hold_eff;
			rdata_nxt[ST_START_BIT] = start_seen_r;
		end
		for (int i = 0; i < NUM_CH; i++) begin
			if (HADDR[7:0] == ADDR_OUT_BASE + 8'(i) * ADDR_STRIDE) begin
				rdata_nxt[WORD_W-1:0] = out_code_r[i];
			end
		end
	end

	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			HRDATA <= RDATA_ZERO;
		end else if (HREADY && HSEL && HTRANS == HTRANS_NONSEQ && !HWRITE) begin
			HRDATA <= rdata_nxt;
		end
	end

	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			HREADYOUT <= 1'b0;
			HRESP <= HRESP_OKAY;
		end else begin
			HREADYOUT <= 1'b1;
			HRESP <= HRESP_OKAY;
		end
	end

	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!RST_N);

	sequence s_start_edge;
		begin_seq && !low_power_hold_eff;
	endsequence

	sequence s_last_capture;
		active_edge && state_r == SEQ_LOAD && step_r == LAST_STEP && !begin_seq && !low_power_hold_eff;
	endsequence

	sequence s_xfr_rise;
		pclk_rise && pin_sync_r.output_transfer && !low_power_hold_eff;
	endsequence

	sequence s_xfr_fall;
		pclk_fall && !low_power_hold_eff;
	endsequence

	property p_begin_load;
		s_start_edge |=> state_r == SEQ_LOAD && step_r == FIRST_STEP + 3'h1;
	endproperty

	property p_end_load;
		s_last_capture |=> state_r == SEQ_IDLE && step_r == FIRST_STEP;
	endproperty

	a_begin_load: assert property (p_begin_load)
		else $error("Load did not begin after a valid start.");

	a_six_words: assert property (p_end_load)
		else $error("Load did not end after the sixth word.");

	a_up_first: assert property (s_start_edge ##0 pin_sync_r.dir |=>
		hold_r[0] == $past(pin_sync_r.word))
		else $error("Upward load did not fill channel 0 first.");

	a_down_first: assert property (s_start_edge ##0 !pin_sync_r.dir |=>
		hold_r[LAST_CH] == $past(pin_sync_r.word))
		else $error("Downward load did not fill channel 5 first.");

	a_hold_edge: assert property (!$stable(hold_r) |->
		$past(active_edge) || $past(low_power_hold_eff))
		else $error("Holding stage changed off the active edge.");

	a_xfr_fall: assert property (s_xfr_rise ##[1:8] s_xfr_fall |=>
		out_code_r == $past(hold_r))
		else $error("Transfer did not move held words at the falling edge.");

	a_out_steady: assert property (!(pclk_fall && xfr_pend_r) && !low_power_hold_eff |=>
		$stable(out_code_r))
		else $error("Output codes changed without a transfer.");

	a_low_power_hold_clear: assert property (low_power_hold_eff |=>
		out_code_r == '0 && hold_r == '0 && state_r == SEQ_IDLE && !xfr_pend_r)
		else $error("Standby did not clear stored state.");

	a_mid_code: assert property (out_code_r[0] == CODE_MAX |=> level_r[0] == '0)
		else $error("Top code did not give the midpoint.");

	a_full_pos: assert property (out_code_r[0] == CODE_RST && pin_sync_r.pol |=>
		$signed(level_r[0]) == $signed({1'b0, CODE_MAX}))
		else $error("Code 0 with polarity high did not give full positive span.");

	a_full_neg: assert property (out_code_r[0] == CODE_RST && !pin_sync_r.pol |=>
		$signed(level_r[0]) == -$signed({1'b0, CODE_MAX}))
		else $error("Code 0 with polarity low did not give full negative span.");

endmodule

// file: panel_host_model.sv
`timescale 1ns/1ps
// Image processor side: panel clock, shared word bus, start and transfer strobes.
module panel_host_model
	import seq_pkg::*;
(
	input wire logic clk,
	output logic pclk,
	output logic [WORD_W-1:0] word,
	output logic start,
	output logic output_transfer
);
	initial begin
		pclk = 1'b0;
		word = CODE_RST;
		start = 1'b0;
		output_transfer = 1'b0;
	end

	// Each panel clock level stands for eight system clocks.
	task automatic edge_pclk();
		repeat (4) @(posedge clk);
		pclk <= ~pclk;
		repeat (4) @(posedge clk);
	endtask

	task automatic frame(input logic [NUM_CH-1:0][WORD_W-1:0] w, input logic st,
		input logic x, input logic es);
		if (pclk === es) begin
			edge_pclk();
		end
		start <= st;
		edge_pclk();
		for (int k = 0; k < NUM_CH; k++) begin
			start <= 1'b0;
			word <= w[k];
			edge_pclk();
			edge_pclk();
		end
		word <= ~w[LAST_CH];
		if (pclk) begin
			edge_pclk();
		end
		output_transfer <= x;
		edge_pclk();
		output_transfer <= 1'b0;
		edge_pclk();
		if (pclk === es) begin
			edge_pclk();
		end
	endtask
endmodule

// file: six_channel_dac_load_sequencer_tb_top.sv
`timescale 1ns/1ps
module six_channel_dac_load_sequencer_tb_top
	import seq_pkg::*;
;
	localparam int MAX_CYCLES = 20000;
	logic clk, rst_n, es, dir, pol, hold, hsel, hwrite, hready, hresp, pclk, start, output_transfer;
	logic [1:0] htrans;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [WORD_W-1:0] word;
	logic [NUM_CH-1:0][WORD_W-1:0] code, w, held, shown;
	logic [NUM_CH-1:0][LEVEL_W-1:0] level;
	int err_count = 0;
	int checks_done = 0;
	int cycles = 0;
	int seed = 44332;
	logic corner = 1'b0;

	column_load_sequencer column_load_sequencer_i (
		.CLOCK(clk), .RST_N(rst_n), .PANEL_CLK(pclk), .INPUT_WORD_BUS(word),
		.SEQUENCE_START(start), .EDGE_SELECT(es), .LOAD_DIRECTION(dir),
		.OUTPUT_TRANSFER(output_transfer), .POLARITY_SELECT(pol), .LOW_POWER_HOLD(hold),
		.HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2),
		.HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready),
		.HRESP(hresp), .COLUMN_CODE(code), .COLUMN_LEVEL(level)
	);

	panel_host_model panel_host_model_i (
		.clk(clk), .pclk(pclk), .word(word), .start(start), .output_transfer(output_transfer)
	);

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	task automatic test_done();
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	always @(posedge clk) begin
		cycles++;
		if (cycles == MAX_CYCLES) begin
			err_count++;
			test_done();
		end
	end

	task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", n, exp, seen);
		end
	endtask

	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h00_0000, a};
		htrans <= HTRANS_NONSEQ;
		hwrite <= wr;
		do @(posedge clk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		do @(posedge clk); while (hready !== 1'b1);
		rd = hrdata;
	endtask

	function automatic logic [LEVEL_W-1:0] lvl(input logic [WORD_W-1:0] c, input logic p);
		logic [LEVEL_W-1:0] m;
		m = {1'b0, CODE_MAX} - {1'b0, c};
		return p ? m : -m;
	endfunction

	function automatic logic [NUM_CH-1:0][WORD_W-1:0] order(
		input logic [NUM_CH-1:0][WORD_W-1:0] v, input logic d);
		for (int ch = 0; ch < NUM_CH; ch++) begin
			order[ch] = d ? v[ch] : v[LAST_CH - ch];
		end
	endfunction

	task automatic check_all();
		for (int ch = 0; ch < NUM_CH; ch++) begin
			check("code", 32'(code[ch]), 32'(shown[ch]));
			check("level", 32'(level[ch]), 32'(lvl(shown[ch], pol)));
			ahb(1'b0, ADDR_OUT_BASE + 8'(ch) * ADDR_STRIDE, RDATA_ZERO);
			check("out reg", rd, {22'h00_0000, shown[ch]});
		end
	endtask

	task automatic run(input logic st, input logic x, input logic en);
		for (int k = 0; k < NUM_CH; k++) begin
			w[k] = WORD_W'($random(seed));
		end
		if (corner) begin
			w[0] = CODE_MAX;
			w[LAST_CH] = CODE_MAX;
		end
		panel_host_model_i.frame(w, st, x, es);
		if (st && en) begin
			held = order(w, dir);
		end
		if (x) begin
			shown = held;
		end
		repeat (8) @(posedge clk);
		check_all();
	endtask

	initial begin
		rst_n = 1'b0;
		{es, dir, pol, hold, hsel, hwrite} = 6'h00;
		htrans = 2'h0;
		haddr = RDATA_ZERO;
		hwdata = RDATA_ZERO;
		held = '0;
		shown = '0;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		ahb(1'b0, ADDR_CONTROL, RDATA_ZERO);
		check("control", rd, {30'h0000_0000, CTRL_RST});
		ahb(1'b0, 8'h40, RDATA_ZERO);
		check("unmapped", rd, RDATA_ZERO);
		check("resp", 32'(hresp), 32'(HRESP_OKAY));
		for (int i = 0; i < 6; i++) begin
			es <= i[1];
			dir <= i[0];
			pol <= 1'($random(seed));
			corner = (i < 2);
			@(posedge clk);
			run(1'b1, 1'b1, 1'b1);
			$display("test %0d done", i);
		end
		run(1'b1, 1'b0, 1'b1);
		run(1'b0, 1'b1, 1'b1);
		$display("test hold and late transfer done");
		ahb(1'b1, ADDR_CONTROL, RDATA_ZERO);
		run(1'b1, 1'b1, 1'b0);
		ahb(1'b1, ADDR_CONTROL, {30'h0000_0000, CTRL_RST});
		$display("test disabled start done");
		ahb(1'b1, ADDR_CONTROL, 32'(CTRL_RST) | (32'h0000_0001 << CTRL_SOFT_LOW_POWER_HOLD_BIT));
		repeat (4) @(posedge clk);
		ahb(1'b0, ADDR_STATUS, RDATA_ZERO);
		check("status", rd, (32'h0000_0001 << ST_LOW_POWER_HOLD_BIT) | (32'(pol) << ST_POL_BIT));
		for (int ch = 0; ch < NUM_CH; ch++) begin
			check("soft standby", 32'(code[ch]), 32'(CODE_RST));
		end
		ahb(1'b1, ADDR_CONTROL, 32'(CTRL_RST));
		held = '0;
		shown = '0;
		$display("test soft standby done");
		run(1'b1, 1'b1, 1'b1);
		hold <= 1'b1;
		pol <= 1'b1;
		repeat (8) @(posedge clk);
		for (int ch = 0; ch < NUM_CH; ch++) begin
			check("standby", 32'(code[ch]), 32'(CODE_RST));
			check("standby level", 32'(level[ch]), 32'(lvl(CODE_RST, 1'b1)));
		end
		hold <= 1'b0;
		repeat (4) @(posedge clk);
		held = '0;
		run(1'b0, 1'b1, 1'b1);
		$display("test standby done");
		test_done();
	end
endmodule
